// File: logic/alarm_threshold_gpio_frame_logic.sv
// Serial frame decoder: alarm threshold programming and general pin exchange
// Functional notes
// - Top bits 11 plus two-bit group enter alarm programming for that group.
// - Later frames: top two bits plus stored group form the target channel.
// - Bit 13 one selects high threshold, zero selects low threshold.
// - Exit bit zero keeps the sequence; next frame is another threshold write.
// - Exit bit one leaves the sequence from the next frame.
// - Without exit bit every word stays threshold data indefinitely.
// - Low ten bits stored; reset high all ones, low all zeros.
// - Thresholds compare with upper ten bits of twelve-bit result.
// - High alarm above high threshold, low alarm below low threshold.
// - Four general pins, each independently input or output.
// - Each select falling edge drives outputs from the last mode command word.
// - Each select falling edge samples inputs, shifted out same frame.
// - Input states go out only if the last mode command word set bit 4.
// - Programming keeps conversion data valid on the serial output.
// - During programming range changes and output data are ignored.
// - Top nibble 0100 writes pin configuration instead of a command.
`timescale 1ns/10ps
`default_nettype none
module alarm_threshold_gpio_frame_logic #(
  parameter int CH_COUNT = 16
) (
  input wire logic mclk_i, // System clock, 50 MHz
  input wire logic sys_rst_i, // Async reset, active high
  input wire logic ce_i, // Clock enable, freezes state when low
  input wire logic sclk_i, // Serial clock pin
  input wire logic cs_n_i, // Frame select pin, active low
  input wire logic serial_in_line_i, // Serial data from host
  output logic serial_out_line_o, // Serial data to host
  output logic serial_out_oe_o, // Serial output drive enable
  input wire logic [3:0] general_input_pin_i, // Pin levels read back
  output logic [3:0] general_output_pin_o, // Pin drive values
  output logic [3:0] general_pin_oe_o, // Pin drive enables
  input wire logic conv_valid_i, // Conversion result strobe
  input wire logic [11:0] conv_data_i, // Conversion result
  input wire logic [3:0] conv_channel_i, // Channel of the result
  output logic alarm_high_o, // High alarm for last result
  output logic alarm_low_o, // Low alarm for last result
  output logic range_sel_o, // Input range request
  output logic alarm_prog_active_o, // In alarm programming
  output logic [3:0] alarm_prog_frames_o // Programming frames seen
);

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation
  logic sclk_s;
  logic cs_n_s;
  logic sin_s;
  logic [3:0] pin_in_s;

  // Select resets idle high so reset release starts no frame
  pin_sync2 #(
    .WIDTH(7),
    .RST_VAL(7'h02)
  ) u_sync (
    .mclk_i(mclk_i),
    .sys_rst_i(sys_rst_i),
    .ce_i(ce_i),
    .async_i({general_input_pin_i, serial_in_line_i, cs_n_i, sclk_i}),
    .sync_o({pin_in_s, sin_s, cs_n_s, sclk_s})
  );

  function automatic logic [3:0] top_nibble(input logic [15:0] w);
    top_nibble = w[frame_logic_pkg::NIB_HI:frame_logic_pkg::NIB_LO];
  endfunction

  function automatic logic is_mode_cmd(input logic [15:0] w);
    logic [3:0] n;
    n = top_nibble(w);
    is_mode_cmd = (n == frame_logic_pkg::MODE_MANUAL_CMD) ||
                  (n == frame_logic_pkg::MODE_AUTO1_CMD) ||
                  (n == frame_logic_pkg::MODE_AUTO2_CMD);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Frame shifter
  logic sclk_d_r;
  logic sclk_d_nxt;
  logic cs_d_r;
  logic cs_d_nxt;
  logic [4:0] bit_cnt_r;
  logic [4:0] bit_cnt_nxt;
  logic [15:0] rx_sh_r;
  logic [15:0] rx_sh_nxt;
  logic [15:0] tx_sh_r;
  logic [15:0] tx_sh_nxt;
  logic cs_fall;
  logic sclk_rise;
  logic sclk_fall;
  logic frame_done;
  logic [15:0] rx_word;
  logic [15:0] tx_word;
  logic rb_pend_r;

  assign cs_fall = cs_d_r & ~cs_n_s;
  assign sclk_rise = ~sclk_d_r & sclk_s;
  assign sclk_fall = sclk_d_r & ~sclk_s;
  assign rx_word = {rx_sh_r[14:0], sin_s};
  // Decode fires only on the sixteenth bit; early select release drops it.
  // Stale count of a cut frame must not fire at the next select fall.
  assign frame_done = sclk_rise & ~cs_n_s & ~cs_d_r &
                      (bit_cnt_r == frame_logic_pkg::LAST_BIT);

  // Conversion data goes out in every frame, programming or not
  always_comb begin
    if (rb_pend_r) begin
      tx_word = {conv_channel_i, conv_data_i[11:4], pin_in_s};
    end else begin
      tx_word = {conv_channel_i, conv_data_i};
    end
  end

  always_comb begin
    sclk_d_nxt = sclk_s;
    cs_d_nxt = cs_n_s;
    bit_cnt_nxt = bit_cnt_r;
    rx_sh_nxt = rx_sh_r;
    tx_sh_nxt = tx_sh_r;
    if (cs_fall) begin
      bit_cnt_nxt = '0;
      tx_sh_nxt = tx_word;
    end else if (~cs_n_s) begin
      if (sclk_rise && bit_cnt_r != frame_logic_pkg::FULL_CNT) begin
        rx_sh_nxt = rx_word;
        bit_cnt_nxt = bit_cnt_r + 5'h01;
      end
      if (sclk_fall) begin
        tx_sh_nxt = {tx_sh_r[14:0], 1'b0};
      end
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sclk_d_r <= 1'b0;
      cs_d_r <= 1'b1;
      bit_cnt_r <= 5'h00;
      rx_sh_r <= 16'h0000;
      tx_sh_r <= 16'h0000;
    end else if (ce_i) begin
      sclk_d_r <= sclk_d_nxt;
      cs_d_r <= cs_d_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      rx_sh_r <= rx_sh_nxt;
      tx_sh_r <= tx_sh_nxt;
    end
  end

  assign serial_out_line_o = tx_sh_r[15];
  assign serial_out_oe_o = ~cs_d_r;

  ////////////////////////////////////////////////////////////////////////////
  // Command decode, thresholds and general pins
  frame_logic_pkg::ctl_state_t state_r;
  frame_logic_pkg::ctl_state_t state_nxt;
  logic [1:0] group_r;
  logic [1:0] group_nxt;
  logic [3:0] pcnt_r;
  logic [3:0] pcnt_nxt;
  logic [3:0] pout_pend_r;
  logic [3:0] pout_pend_nxt;
  logic [3:0] pout_r;
  logic [3:0] pout_nxt;
  logic [3:0] dir_r;
  logic [3:0] dir_nxt;
  logic rb_pend_nxt;
  logic range_r;
  logic range_nxt;
  logic [9:0] hi_thr_r [CH_COUNT];
  logic [9:0] hi_thr_nxt [CH_COUNT];
  logic [9:0] lo_thr_r [CH_COUNT];
  logic [9:0] lo_thr_nxt [CH_COUNT];
  logic [3:0] tgt_ch;

  // Channel built from stored group and the frame's low channel bits
  assign tgt_ch = {group_r,
                   rx_word[frame_logic_pkg::CH_LOW_HI:frame_logic_pkg::CH_LOW_LO]};

  always_comb begin
    state_nxt = state_r;
    group_nxt = group_r;
    pcnt_nxt = pcnt_r;
    pout_pend_nxt = pout_pend_r;
    pout_nxt = pout_r;
    dir_nxt = dir_r;
    rb_pend_nxt = rb_pend_r;
    range_nxt = range_r;
    for (int i = 0; i < CH_COUNT; i++) begin
      hi_thr_nxt[i] = hi_thr_r[i];
      lo_thr_nxt[i] = lo_thr_r[i];
    end
    if (cs_fall) begin
      pout_nxt = pout_pend_r;
    end
    if (frame_done) begin
      case (state_r)
        frame_logic_pkg::ST_NORMAL: begin
          if (rx_word[15:14] == frame_logic_pkg::ALARM_ENTRY_TOP) begin
            state_nxt = frame_logic_pkg::ST_ALARM_PROG;
            group_nxt = rx_word[frame_logic_pkg::GROUP_HI:frame_logic_pkg::GROUP_LO];
            pcnt_nxt = '0;
          end else if (top_nibble(rx_word) == frame_logic_pkg::GPIO_CFG_CMD) begin
            dir_nxt = rx_word[frame_logic_pkg::POUT_HI:frame_logic_pkg::POUT_LO];
          end else if (is_mode_cmd(rx_word)) begin
            // Output values ride in the command word
            pout_pend_nxt = rx_word[frame_logic_pkg::POUT_HI:frame_logic_pkg::POUT_LO];
            rb_pend_nxt = rx_word[frame_logic_pkg::RB_EN_POS];
            range_nxt = rx_word[frame_logic_pkg::RANGE_POS];
          end
        end
        frame_logic_pkg::ST_ALARM_PROG: begin
          // Any word here is threshold data; range and pin data not taken
          if (rx_word[frame_logic_pkg::HL_SEL_POS]) begin
            hi_thr_nxt[tgt_ch] = rx_word[frame_logic_pkg::THR_HI:frame_logic_pkg::THR_LO];
          end else begin
            lo_thr_nxt[tgt_ch] = rx_word[frame_logic_pkg::THR_HI:frame_logic_pkg::THR_LO];
          end
          if (pcnt_r != frame_logic_pkg::PCNT_MAX) begin
            pcnt_nxt = pcnt_r + 4'h1;
          end
          if (rx_word[frame_logic_pkg::EXIT_POS]) begin
            state_nxt = frame_logic_pkg::ST_NORMAL;
          end else begin
            state_nxt = frame_logic_pkg::ST_ALARM_PROG;
          end
        end
        default: begin
          state_nxt = frame_logic_pkg::ST_NORMAL;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      state_r <= frame_logic_pkg::ST_NORMAL;
      group_r <= 2'h0;
      pcnt_r <= 4'h0;
      pout_pend_r <= frame_logic_pkg::GPIO_RST;
      pout_r <= frame_logic_pkg::GPIO_RST;
      dir_r <= frame_logic_pkg::GPIO_RST;
      rb_pend_r <= 1'b0;
      range_r <= 1'b0;
      for (int i = 0; i < CH_COUNT; i++) begin
        hi_thr_r[i] <= frame_logic_pkg::HIGH_THR_RST;
        lo_thr_r[i] <= frame_logic_pkg::LOW_THR_RST;
      end
    end else if (ce_i) begin
      state_r <= state_nxt;
      group_r <= group_nxt;
      pcnt_r <= pcnt_nxt;
      pout_pend_r <= pout_pend_nxt;
      pout_r <= pout_nxt;
      dir_r <= dir_nxt;
      rb_pend_r <= rb_pend_nxt;
      range_r <= range_nxt;
      for (int i = 0; i < CH_COUNT; i++) begin
        hi_thr_r[i] <= hi_thr_nxt[i];
        lo_thr_r[i] <= lo_thr_nxt[i];
      end
    end
  end

  assign general_output_pin_o = pout_r;
  assign general_pin_oe_o = dir_r;
  assign range_sel_o = range_r;
  assign alarm_prog_active_o = (state_r == frame_logic_pkg::ST_ALARM_PROG);
  assign alarm_prog_frames_o = pcnt_r;

  ////////////////////////////////////////////////////////////////////////////
  // Alarm compare
  logic alarm_high_r;
  logic alarm_high_nxt;
  logic alarm_low_r;
  logic alarm_low_nxt;
  logic [9:0] conv_upper;

  // Two lowest result bits are dropped before compare
  assign conv_upper = conv_data_i[11:2];

  always_comb begin
    alarm_high_nxt = alarm_high_r;
    alarm_low_nxt = alarm_low_r;
    if (conv_valid_i && (32'(conv_channel_i) < CH_COUNT)) begin
      alarm_high_nxt = conv_upper > hi_thr_r[conv_channel_i];
      alarm_low_nxt = conv_upper < lo_thr_r[conv_channel_i];
    end
  end

  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      alarm_high_r <= 1'b0;
      alarm_low_r <= 1'b0;
    end else if (ce_i) begin
      alarm_high_r <= alarm_high_nxt;
      alarm_low_r <= alarm_low_nxt;
    end
  end

  assign alarm_high_o = alarm_high_r;
  assign alarm_low_o = alarm_low_r;

endmodule // alarm_threshold_gpio_frame_logic
`default_nettype wire

// File: logic/frame_logic_pkg.sv
// Constants for the alarm threshold and general pin frame decoder
package frame_logic_pkg;
  // Frame shape
  localparam int FRAME_BITS = 16;
  localparam int CNT_W = 5;
  localparam logic [4:0] LAST_BIT = 5'h0F;
  localparam logic [4:0] FULL_CNT = 5'h10;
  // Field positions of the serial input word
  localparam int NIB_HI = 15;
  localparam int NIB_LO = 12;
  localparam int CH_LOW_HI = 15;
  localparam int CH_LOW_LO = 14;
  localparam int HL_SEL_POS = 13;
  localparam int EXIT_POS = 12;
  localparam int GROUP_HI = 13;
  localparam int GROUP_LO = 12;
  localparam int THR_HI = 9;
  localparam int THR_LO = 0;
  localparam int RANGE_POS = 6;
  localparam int RB_EN_POS = 4;
  localparam int POUT_HI = 3;
  localparam int POUT_LO = 0;
  // Widths
  localparam int THR_W = 10;
  localparam int CONV_W = 12;
  localparam int CH_W = 4;
  localparam int GRP_W = 2;
  localparam int GPIO_W = 4;
  localparam int PCNT_W = 4;
  // Command codes in the top nibble
  localparam logic [1:0] ALARM_ENTRY_TOP = 2'h3;
  localparam logic [3:0] GPIO_CFG_CMD = 4'h4;
  localparam logic [3:0] MODE_MANUAL_CMD = 4'h1;
  localparam logic [3:0] MODE_AUTO1_CMD = 4'h2;
  localparam logic [3:0] MODE_AUTO2_CMD = 4'h3;
  // Reset values and frame count limit
  localparam logic [9:0] HIGH_THR_RST = 10'h3FF;
  localparam logic [9:0] LOW_THR_RST = 10'h000;
  localparam logic [3:0] GPIO_RST = 4'h0;
  localparam logic [3:0] PCNT_MAX = 4'hF;
  typedef enum logic {
    ST_NORMAL = 1'b0,
    ST_ALARM_PROG = 1'b1
  } ctl_state_t;
endpackage

// File: logic/pin_sync2.sv
// Two-stage synchroniser for asynchronous pin inputs
`timescale 1ns/10ps
`default_nettype none
module pin_sync2 #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic mclk_i, // System clock
  input wire logic sys_rst_i, // Async reset, active high
  input wire logic ce_i, // Clock enable
  input wire logic [WIDTH-1:0] async_i, // Pin levels
  output logic [WIDTH-1:0] sync_o // Synchronised levels
);
  logic [WIDTH-1:0] meta_r;
  logic [WIDTH-1:0] meta_nxt;
  logic [WIDTH-1:0] sync_r;
  logic [WIDTH-1:0] sync_nxt;

  always_comb begin
    meta_nxt = ce_i ? async_i : meta_r;
    sync_nxt = ce_i ? meta_r : sync_r;
  end

  // Reset level per bit matches each pin's idle level
  always_ff @(posedge mclk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      meta_r <= RST_VAL;
      sync_r <= RST_VAL;
    end else begin
      meta_r <= meta_nxt;
      sync_r <= sync_nxt;
    end
  end

  assign sync_o = sync_r;
endmodule // pin_sync2
`default_nettype wire

// File: sim/alarm_threshold_gpio_frame_logic_assertions.sv
// Port-level checks for the frame decoder
`timescale 1ns/10ps
`default_nettype none
module frame_logic_checker (
  input wire logic mclk_i, // Clock
  input wire logic sys_rst_i, // Reset
  input wire logic cs_n_i, // Frame select
  input wire logic conv_valid_i, // Result strobe
  input wire logic [11:0] conv_data_i, // Result
  input wire logic [3:0] general_output_pin_o, // Pin values
  input wire logic [3:0] general_pin_oe_o, // Pin enables
  input wire logic serial_out_oe_o, // Output drive enable
  input wire logic range_sel_o, // Range
  input wire logic alarm_high_o, // High alarm
  input wire logic alarm_low_o, // Low alarm
  input wire logic alarm_prog_active_o, // Programming
  input wire logic [3:0] alarm_prog_frames_o // Frame count
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (sys_rst_i);
  property p_gpo_at_cs_fall;
    $changed(general_output_pin_o) |-> !cs_n_i &&
      ($past(cs_n_i, 4) || $past(cs_n_i, 5) || $past(cs_n_i, 6));
  endproperty
  a_gpo_at_cs_fall: assert property (p_gpo_at_cs_fall) else $error("pins moved mid frame");
  property p_prog_holds;
    alarm_prog_active_o && $past(alarm_prog_active_o, 8) |-> $stable(general_output_pin_o)
      && $stable(range_sel_o) && $stable(general_pin_oe_o);
  endproperty
  a_prog_holds: assert property (p_prog_holds) else $error("setting taken in programming");
  property p_alarm_on_strobe;
    $changed(alarm_high_o) || $changed(alarm_low_o) |-> $past(conv_valid_i);
  endproperty
  a_alarm_on_strobe: assert property (p_alarm_on_strobe) else $error("alarm without result");
  property p_top_never_high;
    conv_valid_i && conv_data_i[11:2] == 10'h3FF |=> !alarm_high_o;
  endproperty
  a_top_never_high: assert property (p_top_never_high) else $error("high alarm at top");
  property p_zero_never_low;
    conv_valid_i && conv_data_i[11:2] == 10'h000 |=> !alarm_low_o;
  endproperty
  a_zero_never_low: assert property (p_zero_never_low) else $error("low alarm at zero");
  property p_count_step;
    $changed(alarm_prog_frames_o) |-> alarm_prog_frames_o == 4'h0 ||
      alarm_prog_frames_o == $past(alarm_prog_frames_o) + 4'h1;
  endproperty
  a_count_step: assert property (p_count_step) else $error("frame count jumped");
  property p_entry_clear;
    $rose(alarm_prog_active_o) |-> alarm_prog_frames_o == 4'h0;
  endproperty
  a_entry_clear: assert property (p_entry_clear) else $error("count not cleared");
  property p_state_in_frame;
    $changed(alarm_prog_active_o) |-> !$past(cs_n_i, 3);
  endproperty
  a_state_in_frame: assert property (p_state_in_frame) else $error("state moved idle");
  property p_oe_in_frame;
    !cs_n_i && !$past(cs_n_i) && !$past(cs_n_i, 2) && !$past(cs_n_i, 3) |-> serial_out_oe_o;
  endproperty
  a_oe_in_frame: assert property (p_oe_in_frame) else $error("output idle in frame");
endmodule // frame_logic_checker
bind alarm_threshold_gpio_frame_logic frame_logic_checker i_chk (.mclk_i, .sys_rst_i,
  .cs_n_i, .conv_valid_i, .conv_data_i, .general_output_pin_o, .general_pin_oe_o,
  .range_sel_o, .alarm_high_o, .alarm_low_o, .alarm_prog_active_o, .alarm_prog_frames_o,
  .serial_out_oe_o);
`default_nettype wire

// File: sim/frame_host_model.sv
// Serial master model that sends frames to the decoder
`timescale 1ns/10ps
`default_nettype none
module frame_host_model (
  input wire logic mclk_i, // Bench clock
  input wire logic sout_i, // Serial data from device
  output logic sclk_o, // Serial clock, still outside frames
  output logic cs_n_o, // Frame select
  output logic sin_o // Serial data to device
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    sin_o = 1'b0;
  end
  // Sends n bits MSB first; n below 16 aborts the frame
  task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] r);
    r = '0;
    @(posedge mclk_i);
    cs_n_o <= 1'b0;
    repeat (4) @(posedge mclk_i);
    for (int i = 0; i < n; i++) begin
      sin_o <= w[15-i];
      repeat (4) @(posedge mclk_i);
      sclk_o <= 1'b1;
      repeat (3) @(posedge mclk_i);
      @(negedge mclk_i);
      r[15-i] = sout_i;
      @(posedge mclk_i);
      sclk_o <= 1'b0;
    end
    repeat (4) @(posedge mclk_i);
    cs_n_o <= 1'b1;
    // Idle line flips so no stale bit looks valid
    sin_o <= ~sin_o;
    repeat (8) @(posedge mclk_i);
  endtask
endmodule // frame_host_model
`default_nettype wire

// File: sim/test_alarm_threshold_gpio_frame_logic.sv
// Self-checking bench for the frame decoder
`timescale 1ns/10ps
`default_nettype none
module test_alarm_threshold_gpio_frame_logic;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic cv = 1'b0;
  logic [11:0] cd = 12'hA5C;
  logic [3:0] cc = 4'h5;
  logic [3:0] pin_in = 4'h6;
  logic ce = 1'b1;
  logic sclk, cs_n, sin, sout, sout_oe, ahi, alo, rng, act;
  logic [3:0] pin_out, goe, pfr;
  logic [15:0] rx;
  int n_fail = 0;
  int tests_run = 0;
  initial forever #10 clk = ~clk;
  alarm_threshold_gpio_frame_logic #(.CH_COUNT(16)) i_dut (.mclk_i(clk), .sys_rst_i(rst),
    .ce_i(ce), .sclk_i(sclk), .cs_n_i(cs_n), .serial_in_line_i(sin),
    .serial_out_line_o(sout), .serial_out_oe_o(sout_oe), .general_input_pin_i(pin_in),
    .general_output_pin_o(pin_out), .general_pin_oe_o(goe), .conv_valid_i(cv),
    .conv_data_i(cd), .conv_channel_i(cc), .alarm_high_o(ahi), .alarm_low_o(alo),
    .range_sel_o(rng), .alarm_prog_active_o(act), .alarm_prog_frames_o(pfr));
  frame_host_model i_host (.mclk_i(clk), .sout_i(sout), .sclk_o(sclk), .cs_n_o(cs_n),
    .sin_o(sin));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic fr(input logic [15:0] w, input logic rb);
    i_host.xfer(w, 16, rx);
    chk(rx, rb ? {cc, cd[11:4], pin_in} : {cc, cd});
  endtask
  task automatic alm(input logic [3:0] ch, input logic [11:0] d, input logic [1:0] e);
    @(posedge clk);
    cv <= 1'b1;
    cc <= ch;
    cd <= d;
    @(posedge clk);
    cv <= 1'b0;
    @(negedge clk);
    chk({14'h0, ahi, alo}, {14'h0, e});
  endtask
  task automatic st(input logic a, input logic [3:0] f, input logic r, input logic [3:0] o,
    input logic [3:0] oe);
    @(negedge clk);
    chk({1'b0, act, pfr, rng, pin_out, goe, sout_oe}, {1'b0, a, f, r, o, oe, 1'b0});
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    st(1'b0, 4'h0, 1'b0, 4'h0, 4'h0);
    alm(4'h3, 12'hFFF, 2'h0);
    alm(4'h3, 12'h000, 2'h0);
    $display("test reset done");
  endtask
  task automatic t_gpio;
    fr(16'h400A, 1'b0);
    st(1'b0, 4'h0, 1'b0, 4'h0, 4'hA);
    fr(16'h105C, 1'b0);
    @(negedge clk);
    chk({12'h0, pin_out}, 16'h0);
    fr(16'h1043, 1'b1);
    st(1'b0, 4'h0, 1'b1, 4'hC, 4'hA);
    fr(16'h0000, 1'b0);
    st(1'b0, 4'h0, 1'b1, 4'h3, 4'hA);
    $display("test gpio done");
  endtask
  task automatic t_alarm;
    fr(16'hE000, 1'b0);
    st(1'b1, 4'h0, 1'b1, 4'h3, 4'hA);
    fr(16'h6100, 1'b0);
    st(1'b1, 4'h1, 1'b1, 4'h3, 4'hA);
    fr(16'h5080, 1'b0);
    fr(16'h0000, 1'b0);
    @(negedge clk);
    chk({15'h0, act}, 16'h0);
    alm(4'h9, 12'h404, 2'h2);
    alm(4'h9, 12'h400, 2'h0);
    alm(4'h9, 12'h1FC, 2'h1);
    alm(4'h8, 12'hFFF, 2'h0);
    alm(4'h5, 12'h1FC, 2'h0);
    $display("test alarm done");
  endtask
  task automatic t_abort;
    fr(16'hC000, 1'b0);
    i_host.xfer(16'h2000, 8, rx);
    st(1'b1, 4'h0, 1'b1, 4'h3, 4'hA);
    fr(16'h400F, 1'b0);
    st(1'b1, 4'h1, 1'b1, 4'h3, 4'hA);
    fr(16'h1000, 1'b0);
    fr(16'h0000, 1'b0);
    @(negedge clk);
    chk({10'h0, act, rng, pin_out}, {10'h0, 1'b0, 1'b1, 4'h3});
    alm(4'h0, 12'h004, 2'h0);
    alm(4'h1, 12'h038, 2'h1);
    $display("test abort done");
  endtask
  // Enable low must freeze the alarm levels left by the last test
  task automatic t_freeze;
    @(posedge clk);
    ce <= 1'b0;
    alm(4'h9, 12'h404, 2'h1);
    @(posedge clk);
    ce <= 1'b1;
    $display("test freeze done");
  endtask
  task automatic stop_test;
    $display("checks %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    t_reset;
    t_gpio;
    t_alarm;
    t_abort;
    t_freeze;
    stop_test;
  end
  // Hang guard
  initial begin
    repeat (20000) @(posedge clk);
    n_fail++;
    stop_test;
  end
endmodule // test_alarm_threshold_gpio_frame_logic
`default_nettype wire
